//--- rcd_rc_detect.sv
// RC detect timing measurement unit with Avalon-MM register slave
//
// Notes on behaviour
// - Clock select 0..3 gives counter ticks of 48, 24, 12, 6 MHz; the code divides 200 MHz by 4, giving 50, 25, 12.5, 6.25 MHz.
// - Clearing enable returns to Reset, stops counting, clears status flags.
// - Setting enable moves Reset to Armed.
// - Setting start begins the Discharged phase.
// - Error set if pin stays high in discharge or counter saturates charging.
// - Error marks result invalid; error reads zero in Reset.
// - Discharge complete flag clears in Reset, sets when discharge ends.
// - Done flag clears in Reset, sets when measurement ends.
// - Result register holds the count in bits 15:0, read-only, resets zero.
// - Control at offset 00h, result at offset 04h.
// - Charge counter starts at zero, stops and stores count on crossing.
// - Discharged moves to Charged when the counter reaches its maximum.
// - Done holds until software clears enable.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "rcd_defines.svh"

module rcd_rc_detect #(
	parameter int TICK_CYCLES = `RCD_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	// Avalon-MM slave
	input  wire logic [3:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	// Threshold comparator, high while pin is above threshold
	input  wire logic         rc_above_threshold,
	// Pin discharge drive and interrupt
	output logic              rc_discharge_drive,
	output logic              irq
);
	import rcd_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		rcd_phase_t   phase;
		rcd_clk_sel_t clk_sel;
		logic         enable;
		logic         start;
		logic         measurement_error_flag;
		logic         discharge_complete_flag;
		logic         done_flag;
		logic [15:0]  result;
		logic [15:0]  count;
		logic [7:0]   prescale;
		logic [3:0]   divide;
		logic         sync_1;
		logic         sync_2;
		logic [2:0]   int_status;
		logic [2:0]   int_mask;
		logic         ack;
		logic [31:0]  readdata;
		logic         discharge_drive;
		logic         irq;
	} rcd_state_t;

	rcd_state_t st;
	rcd_state_t next_st;

	logic        acc;
	logic        wr_ok;
	logic        tick;
	logic [3:0]  div_lim;
	logic [31:0] ctrl_word;

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[`RCD_CLK_SEL_HI:`RCD_CLK_SEL_LO] = st.clk_sel;
		ctrl_word[`RCD_ENABLE_BIT]    = st.enable;
		ctrl_word[`RCD_START_BIT]     = st.start;
		ctrl_word[`RCD_ERROR_BIT]     = st.measurement_error_flag;
		ctrl_word[`RCD_DISCHARGE_BIT] = st.discharge_complete_flag;
		ctrl_word[`RCD_DONE_BIT]      = st.done_flag;
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		// One wait cycle per access; the ack cycle drops waitrequest
		acc   = (avs_read || avs_write) && !st.ack;
		wr_ok = acc && avs_write;
		next_st.ack = acc;

		next_st.sync_1 = rc_above_threshold;
		next_st.sync_2 = st.sync_1;

		// counter tick divided from ref clock, then by 1,2,4,8
		div_lim = 4'((1 << st.clk_sel) - 1);
		tick = 1'b0;
		if (st.phase == RCD_DISCHARGED || st.phase == RCD_CHARGED) begin
			if (st.prescale == 8'(TICK_CYCLES - 1)) begin
				next_st.prescale = 8'h00;
				if (st.divide >= div_lim) begin
					next_st.divide = 4'h0;
					tick = 1'b1;
				end else begin
					next_st.divide = st.divide + 4'h1;
				end
			end else begin
				next_st.prescale = st.prescale + 8'h01;
			end
		end else begin
			// counter clocks gated outside active phases
			next_st.prescale = 8'h00;
			next_st.divide   = 4'h0;
		end

		case (st.phase)
			RCD_RESET: begin
				if (st.enable) begin
					next_st.phase = RCD_ARMED;
				end
			end
			RCD_ARMED: begin
				if (st.start) begin
					next_st.phase = RCD_DISCHARGED;
					next_st.count = 16'h0000;
				end
			end
			RCD_DISCHARGED: begin
				if (tick) begin
					if (st.count == `RCD_COUNT_MAX) begin
						next_st.phase = RCD_CHARGED;
						next_st.discharge_complete_flag = 1'b1;
						next_st.int_status[`RCD_DISCHARGE_BIT] = 1'b1;
						if (st.sync_2) begin
							next_st.measurement_error_flag = 1'b1;
						end
						next_st.count = 16'h0000;
					end else begin
						next_st.count = st.count + 16'h0001;
					end
				end
			end
			RCD_CHARGED: begin
				if (st.sync_2) begin
					next_st.result    = st.count;
					next_st.phase     = RCD_DONE;
					next_st.done_flag = 1'b1;
					next_st.int_status[`RCD_DONE_BIT] = 1'b1;
				end else if (tick) begin
					if (st.count == `RCD_COUNT_MAX) begin
						next_st.result    = st.count;
						next_st.measurement_error_flag = 1'b1;
						next_st.int_status[`RCD_ERROR_BIT] = 1'b1;
						next_st.phase     = RCD_DONE;
						next_st.done_flag = 1'b1;
						next_st.int_status[`RCD_DONE_BIT] = 1'b1;
					end else begin
						next_st.count = st.count + 16'h0001;
					end
				end
			end
			RCD_DONE: begin
			end
			default: next_st.phase = RCD_RESET;
		endcase

		// Error during discharge also raises its event bit
		if (st.phase == RCD_DISCHARGED && next_st.measurement_error_flag && !st.measurement_error_flag) begin
			next_st.int_status[`RCD_ERROR_BIT] = 1'b1;
		end

		// ======================================================
		// Register writes
		if (wr_ok) begin
			case (avs_address)
				`RCD_CONTROL_OFS: begin
					if (avs_byteenable[1]) begin
						next_st.clk_sel = avs_writedata[`RCD_CLK_SEL_HI:`RCD_CLK_SEL_LO];
					end
					// status and reserved bits are not writable
					if (avs_byteenable[0]) begin
						next_st.enable = avs_writedata[`RCD_ENABLE_BIT];
						next_st.start  = avs_writedata[`RCD_START_BIT];
					end
				end
				`RCD_INT_STATUS_OFS: begin
					// Write one clears; a same-cycle event wins
					if (avs_byteenable[0]) begin
						next_st.int_status = next_st.int_status & ~(avs_writedata[2:0] & ~(next_st.int_status & ~st.int_status));
					end
				end
				`RCD_INT_MASK_OFS: begin
					if (avs_byteenable[0]) begin
						next_st.int_mask = avs_writedata[2:0];
					end
				end
				default: begin
				end
			endcase
			// clearing enable forces Reset and clears status
			if (avs_address == `RCD_CONTROL_OFS && avs_byteenable[0] && !avs_writedata[`RCD_ENABLE_BIT]) begin
				next_st.phase = RCD_RESET;
				next_st.measurement_error_flag  = 1'b0;
				next_st.discharge_complete_flag = 1'b0;
				next_st.done_flag = 1'b0;
				next_st.count     = 16'h0000;
			end
		end

		// ======================================================
		// Read data, registered for the ack cycle
		next_st.readdata = 32'h0000_0000;
		if (acc && avs_read) begin
			case (avs_address)
				`RCD_CONTROL_OFS:    next_st.readdata = ctrl_word;
				`RCD_RESULT_OFS:     next_st.readdata = {16'h0000, st.result};
				`RCD_INT_STATUS_OFS: next_st.readdata = {29'h0, st.int_status};
				`RCD_INT_MASK_OFS:   next_st.readdata = {29'h0, st.int_mask};
				default:             next_st.readdata = 32'h0000_0000;
			endcase
		end

		// Pin held low only while discharging
		next_st.discharge_drive = (next_st.phase == RCD_DISCHARGED);
		next_st.irq = |(next_st.int_status & next_st.int_mask);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '{
				phase:    RCD_RESET,
				clk_sel:  `RCD_CLK_SEL_RST,
				result:   `RCD_RESULT_RST,
				default:  '0
			};
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata       = st.readdata;
	assign avs_waitrequest    = (avs_read || avs_write) && !st.ack;
	assign rc_discharge_drive = st.discharge_drive;
	assign irq                = st.irq;

endmodule

//--- rcd_defines.svh
// Register offsets, field positions, reset values and timing counts for the RC detect block
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH

`define RCD_CONTROL_OFS      4'h0
`define RCD_RESULT_OFS       4'h4
`define RCD_INT_STATUS_OFS   4'h8
`define RCD_INT_MASK_OFS     4'hC

`define RCD_CLK_SEL_HI       9
`define RCD_CLK_SEL_LO       8
`define RCD_ENABLE_BIT       7
`define RCD_START_BIT        6
`define RCD_ERROR_BIT        2
`define RCD_DISCHARGE_BIT    1
`define RCD_DONE_BIT         0

`define RCD_CLK_SEL_RST      2'h0
`define RCD_RESULT_RST       16'h0000
`define RCD_COUNT_MAX        16'hFFFF

// Counter clock in MHz for select value 0; each step halves it
`define RCD_BASE_CLK_MHZ     48
`define RCD_REF_CLK_MHZ      200
// Ref clock cycles per tick of the fastest counter clock, rounded down
`define RCD_TICK_CYCLES      (`RCD_REF_CLK_MHZ / `RCD_BASE_CLK_MHZ)

`endif

//--- rcd_pkg.sv
// Types shared by the RC detect block
package rcd_pkg;

	typedef enum logic [2:0] {
		RCD_RESET      = 3'h0,
		RCD_ARMED      = 3'h1,
		RCD_DISCHARGED = 3'h3,
		RCD_CHARGED    = 3'h2,
		RCD_DONE       = 3'h6
	} rcd_phase_t;

	typedef logic [1:0] rcd_clk_sel_t;

endpackage

//--- rcd_rc_detect_assertions.sv
// Port checks for the RC detect block
`timescale 1ns/1ps
module rcd_chk #(
	parameter int TICK_CYCLES = 4
) (
	// Clock, reset, bus
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Pin side
	input wire logic        rc_above_threshold,
	input wire logic        rc_discharge_drive,
	input wire logic        irq
);
	wire logic rd_ok = avs_read && !avs_waitrequest;
	wire logic wr_ok = avs_write && !avs_waitrequest;
	wire logic ctl_wr = wr_ok && avs_address == 4'h0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// Assertions
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait state");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer late");
	a_rdata_idle: assert property (!rd_ok |-> avs_readdata == 32'h0)
		else $error("stray read data");
	a_ctl_reserved: assert property (rd_ok && avs_address == 4'h0 |-> avs_readdata[31:10] == 22'h0 && avs_readdata[5:3] == 3'h0)
		else $error("reserved control bits set");
	a_result_upper: assert property (rd_ok && avs_address == 4'h4 |-> avs_readdata[31:16] == 16'h0)
		else $error("result upper bits set");
	a_drive_start: assert property (ctl_wr && avs_writedata[7:6] == 2'h3 && !rc_discharge_drive |-> ##[1:3] rc_discharge_drive)
		else $error("discharge not started");
	a_drive_hold: assert property ($rose(rc_discharge_drive) |-> rc_discharge_drive[*8])
		else $error("discharge cut short");
	a_drive_stop: assert property (ctl_wr && !avs_writedata[7] |-> ##[1:3] !rc_discharge_drive)
		else $error("discharge kept after disable");
	a_irq_held: assert property (!avs_write[*3] ##0 irq |=> irq)
		else $error("irq dropped without write");
endmodule
bind rcd_rc_detect rcd_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.ref_clk(ref_clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rc_above_threshold(rc_above_threshold), .rc_discharge_drive(rc_discharge_drive), .irq(irq));

//--- rcd_rc_model.sv
// RC network and threshold comparator model
`timescale 1ns/1ps
module rcd_rc_model #(
	parameter int CHG = 40
) (
	// Clock and pin
	input wire logic  ref_clk,
	input wire logic  rc_discharge_drive,
	output logic      rc_above_threshold
);
	int n = CHG;
	always @(posedge ref_clk) begin
		if (rc_discharge_drive)
			n <= 0;
		else if (n < CHG)
			n <= n + 1;
	end
	assign rc_above_threshold = (n >= CHG);
endmodule

//--- rcd_rc_detect_tb_top.sv
// Register-level testbench for the RC detect block
`timescale 1ns/1ps
module rcd_rc_detect_tb_top;
	localparam int CHG = 40;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	wire logic [31:0] q;
	wire logic   wt, above, drv, irq;
	int          fails = 0;
	int          cmp_count = 0;
	always #2.5 ref_clk = ~ref_clk;
	rcd_rc_detect #(.TICK_CYCLES(1)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(q),
		.avs_waitrequest(wt), .rc_above_threshold(above), .rc_discharge_drive(drv), .irq(irq));
	rcd_rc_model #(.CHG(CHG)) pin_u (.ref_clk(ref_clk), .rc_discharge_drive(drv), .rc_above_threshold(above));
	task automatic give_verdict();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bus access: request held until the rising edge that samples waitrequest low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wt !== 1'b0 && n < 50);
		rdat = q;
		if (n >= 50) begin
			fails++;
			give_verdict();
		end
		rd <= 1'b0;
		wr <= 1'b0;
		// One idle edge so the next call never re-raises at the release edge
		@(posedge ref_clk);
	endtask
	initial begin
		int n;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		bus(0, 4'h0, 32'h0);
		chk("control", 32'h0, rdat);
		bus(0, 4'h4, 32'h0);
		chk("result", 32'h0, rdat);
		$display("test reset done");
		bus(1, 4'h0, 32'h300);
		bus(0, 4'h0, 32'h0);
		chk("clk_sel", 32'h300, rdat);
		// clock select and start cleared with enable
		bus(1, 4'h0, 32'h0);
		// clock select kept at zero while enabled
		bus(1, 4'h0, 32'hFFFFFCBF);
		bus(0, 4'h0, 32'h0);
		chk("control", 32'h80, rdat);
		bus(1, 4'h4, 32'hFFFF);
		bus(0, 4'h4, 32'h0);
		chk("result", 32'h0, rdat);
		bus(1, 4'hC, 32'h1);
		$display("test registers done");
		// Settling wait scaled down with the counter tick
		// enable to start gap
		repeat (200) @(posedge ref_clk);
		// start rises with enable one, clock select unchanged
		bus(1, 4'h0, 32'hC0);
		chk("drive", 32'h1, 32'(drv));
		n = 0;
		do begin
			bus(0, 4'h0, 32'h0);
			n++;
		end while (rdat[0] !== 1'b1 && n < 30000);
		chk("control", 32'hC3, rdat);
		bus(0, 4'h4, 32'h0);
		chk("result_range", 32'h1, 32'(rdat >= CHG - 2 && rdat <= CHG + 6));
		chk("irq", 32'h1, 32'(irq));
		bus(0, 4'h8, 32'h0);
		chk("int_status", 32'h3, rdat);
		bus(1, 4'h8, 32'h1);
		bus(0, 4'h8, 32'h0);
		chk("int_status", 32'h2, rdat);
		chk("irq", 32'h0, 32'(irq));
		$display("test measurement done");
		bus(1, 4'h0, 32'h0);
		bus(0, 4'h0, 32'h0);
		chk("control", 32'h0, rdat);
		$display("test disable done");
		give_verdict();
	end
endmodule
